// ### hdl/dspi_top.sv
/*
  Pin-level system interface of a 16-bit signal processor: external bus
  sequencer, multiprocessor pins, reset and boot sampling, external
  interrupts, timer pulse, machine clock and general pins.
  Assumes the core issues one bus request at a time and holds it until
  ack, and that all pins are asynchronous to clk_sys.
*/
module dspi_top
  import dspi_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // register port
  input wire logic [2:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [15:0] regRdata,
  // core side
  input wire dspi_pkg::dspi_req_t coreReq,
  output logic coreAck,
  output logic [15:0] coreRdata,
  output logic coreRun,
  output logic coreStart,
  input wire logic branchTest,
  output logic branchTaken,
  output logic irqPending,
  output logic [2:0] irqNum,
  input wire logic irqAck,
  output logic flashSel,
  input wire logic [15:0] flashRdata,
  input wire logic timerEnable,
  input wire logic ssMultichan,
  input wire logic ssFrameSync,
  input wire logic oscInternalEn,
  // external bus pins
  output dspi_pkg::dspi_bus_t busPins,
  output logic busOe,
  output logic dataOe,
  input wire logic [15:0] dataIn,
  input wire logic readyIn,
  // system pins
  input wire logic floatAllN,
  output logic ctrlOe,
  output logic busCycleStrobeN,
  output logic busRequestOutN,
  output logic holdAcknowledgeN,
  output logic externalFlagOut,
  input wire logic branchConditionInN,
  input wire logic [3:0] gpPinsIn,
  output logic [3:0] gpPinsOut,
  output logic [3:0] gpPinsOe,
  input wire logic resetInN,
  input wire logic bootMemorySelect,
  input wire logic nmiInN,
  input wire logic holdOrIrq1N,
  input wire logic extIrqTwoN,
  input wire logic extIrqThreeN,
  output logic timerPulseOut,
  output logic machineCycleClock,
  input wire logic inputClockPin,
  output logic oscOutputPin
);
  import dspi_pkg::*;

  // ==========================================================
  // state
  typedef struct packed {
    logic [SY_W-1:0] syA;
    logic [SY_W-1:0] syB;
    logic [3:0] irqPrev;
    dspi_bus_e_t bus;
    dspi_req_t req;
    logic mcPh;
    logic [4:0] rstCnt;
    logic run;
    logic start;
    logic [15:0] processor_mode_status_reg;
    logic icrMode;
    logic [2:0] interrupt_mask_reg;
    logic [3:0] interrupt_flag_reg;
    logic xf;
    logic global_irq_mask_bit;
    logic [7:0] uctl;
    logic [15:0] tPrd;
    logic [15:0] tCnt;
    logic timer_pulse_out;
    logic [15:0] regRd;
    logic [15:0] coreRd;
    logic ack;
    logic rdyOk;
    logic brTaken;
    logic oscOut;
  } dspi_state_t;

  dspi_state_t st_r;
  dspi_state_t st_nxt;

  logic mcEn;
  logic rstAny;
  logic [3:0] irqLvlN;
  logic [3:0] irqFall;
  logic [3:0] irqClr;
  logic [2:0] irqLive;
  logic [15:0] regView;
  logic extRead;

  // machine cycle starts on the edge that raises the machine clock
  assign mcEn = ~st_r.mcPh;
  // pin reset acts like the system reset on all control state but the machine clock phase, which keeps toggling
  assign rstAny = reset | ~st_r.syB[SY_RST];
  assign irqLvlN = st_r.syB[SY_IRQ1+2:SY_NMI];
  assign irqFall = st_r.irqPrev & ~irqLvlN;
  assign irqLive = st_r.interrupt_flag_reg[2:0] & st_r.interrupt_mask_reg & {3{~st_r.global_irq_mask_bit}};

  // ==========================================================
  // register read view
  always_comb begin
    regView = 16'h0000;
    case (regAddr)
      REG_PROCESSOR_MODE_STATUS_REG: regView = st_r.processor_mode_status_reg;
      REG_ICR: regView[ICR_MODE] = st_r.icrMode;
      REG_IMR: regView[2:0] = st_r.interrupt_mask_reg;
      REG_IFR: regView[3:0] = st_r.interrupt_flag_reg;
      REG_CTRL: regView[1:0] = {st_r.global_irq_mask_bit, st_r.xf};
      REG_UART: regView[11:0] = {st_r.syB[SY_GP+3:SY_GP], st_r.uctl};
      REG_TPRD: regView = st_r.tPrd;
      REG_TCNT: regView = st_r.tCnt;
      default: regView = 16'h0000;
    endcase
  end

  // ==========================================================
  // interrupt priority: nmi first, then irq one to three
  always_comb begin
    irqNum = 3'h0;
    if (st_r.interrupt_flag_reg[IFR_NMI]) begin
      irqNum = 3'h4;
    end else if (irqLive[0]) begin
      irqNum = 3'h1;
    end else if (irqLive[1]) begin
      irqNum = 3'h2;
    end else if (irqLive[2]) begin
      irqNum = 3'h3;
    end
  end
  assign irqPending = st_r.interrupt_flag_reg[IFR_NMI] | (|irqLive);

  // flags cleared by the core taking the vector
  always_comb begin
    irqClr = 4'h0;
    if (irqAck && irqPending) begin
      irqClr = (irqNum == 3'h4) ? 4'h8 : 4'(4'h1 << (irqNum - 3'h1));
    end
  end

  // ==========================================================
  // next state
  always_comb begin
    st_nxt = st_r;
    // two-stage synchronisers, first stage read only here
    st_nxt.syA = {gpPinsIn, bootMemorySelect, extIrqThreeN, extIrqTwoN,
                  holdOrIrq1N, nmiInN, branchConditionInN, readyIn,
                  resetInN, floatAllN};
    st_nxt.syB = st_r.syA;
    st_nxt.irqPrev = irqLvlN;
    st_nxt.mcPh = ~st_r.mcPh;
    st_nxt.ack = 1'b0;
    st_nxt.start = 1'b0;
    st_nxt.brTaken = branchTest & ~st_r.syB[SY_BIO];
    // crystal mode echoes the inverted clock pin
    st_nxt.oscOut = oscInternalEn & ~inputClockPin;
    st_nxt.regRd = regRd ? regView : 16'h0000;

    // software writes
    if (regWr) begin
      case (regAddr)
        REG_PROCESSOR_MODE_STATUS_REG: st_nxt.processor_mode_status_reg[15:1] = regWdata[15:1]; // boot bit is read only
        REG_ICR: st_nxt.icrMode = regWdata[ICR_MODE];
        REG_IMR: st_nxt.interrupt_mask_reg = regWdata[2:0];
        REG_CTRL: begin
          st_nxt.xf = regWdata[CTRL_XF];
          st_nxt.global_irq_mask_bit = regWdata[CTRL_GLOBAL_IRQ_MASK_BIT];
        end
        REG_UART: st_nxt.uctl = regWdata[7:0];
        REG_TPRD: st_nxt.tPrd = regWdata;
        default: st_nxt.tPrd = st_r.tPrd;
      endcase
    end

    // flags: an edge in the same cycle as a clear wins
    st_nxt.interrupt_flag_reg = st_r.interrupt_flag_reg & ~irqClr;
    if (regWr && regAddr == REG_IFR) begin
      st_nxt.interrupt_flag_reg = st_nxt.interrupt_flag_reg & ~regWdata[3:0];
    end
    st_nxt.interrupt_flag_reg[IFR_NMI] = st_nxt.interrupt_flag_reg[IFR_NMI] | irqFall[0];
    st_nxt.interrupt_flag_reg[0] = st_nxt.interrupt_flag_reg[0] | (irqFall[1] & st_r.icrMode);
    st_nxt.interrupt_flag_reg[2:1] = st_nxt.interrupt_flag_reg[2:1] | irqFall[3:2];

    // timer counts machine cycles, pulse lasts one machine cycle
    if (mcEn) begin
      st_nxt.timer_pulse_out = 1'b0;
      if (timerEnable && st_r.run) begin
        if (st_r.tCnt == 16'h0000) begin
          st_nxt.tCnt = st_r.tPrd;
          st_nxt.timer_pulse_out = 1'b1;
        end else begin
          st_nxt.tCnt = st_r.tCnt - 16'h0001;
        end
      end
    end

    // writing the reload value restarts the count, so a new period starts at once
    if (regWr && regAddr == REG_TPRD) begin
      st_nxt.tCnt = regWdata;
    end

    // reset release wait, then fetch from zero
    if (mcEn && !st_r.run) begin
      if (st_r.rstCnt == RESET_WAIT_MC - 5'h01) begin
        st_nxt.run = 1'b1;
        st_nxt.start = 1'b1;
      end else begin
        st_nxt.rstCnt = st_r.rstCnt + 5'h01;
      end
    end

    // bus sequencer, one step per machine cycle
    if (mcEn) begin
      case (st_r.bus)
        B_IDLE: begin
          st_nxt.rdyOk = 1'b0;
          if (!st_r.icrMode && !st_r.syB[SY_IRQ1]) begin
            st_nxt.bus = B_HOLD;
          end else if (coreReq.valid && st_r.run && !st_r.ack) begin
            st_nxt.req = coreReq;
            if (coreReq.space == SP_PROG && !st_r.processor_mode_status_reg[PROCESSOR_MODE_STATUS_REG_BOOT]) begin
              st_nxt.bus = B_FLASH;
            end else begin
              st_nxt.bus = B_EXT;
            end
          end
        end
        B_EXT: begin
          // first look sees a ready synchronised before the strobe fell
          st_nxt.rdyOk = 1'b1;
          if (st_r.syB[SY_RDY] && st_r.rdyOk) begin
            st_nxt.bus = B_IDLE;
            st_nxt.ack = 1'b1;
            st_nxt.coreRd = dataIn;
          end
        end
        B_FLASH: begin
          st_nxt.bus = B_IDLE;
          st_nxt.ack = 1'b1;
          st_nxt.coreRd = flashRdata;
        end
        B_HOLD: begin
          if (st_r.icrMode || st_r.syB[SY_IRQ1]) begin
            st_nxt.bus = B_IDLE;
          end
        end
        default: st_nxt.bus = B_IDLE;
      endcase
    end

    // reset values; boot select caught while reset stands
    if (rstAny) begin
      st_nxt.bus = B_IDLE;
      st_nxt.req = '0;
      st_nxt.rstCnt = 5'h00;
      st_nxt.run = 1'b0;
      st_nxt.start = 1'b0;
      st_nxt.ack = 1'b0;
      st_nxt.processor_mode_status_reg = PROCESSOR_MODE_STATUS_REG_RST;
      st_nxt.processor_mode_status_reg[PROCESSOR_MODE_STATUS_REG_BOOT] = st_r.syB[SY_BOOT];
      st_nxt.icrMode = 1'b0;
      st_nxt.interrupt_mask_reg = IMR_RST;
      st_nxt.interrupt_flag_reg = 4'h0;
      st_nxt.xf = 1'b0;
      st_nxt.global_irq_mask_bit = 1'b1;
      st_nxt.uctl = UART_RST;
      st_nxt.tPrd = TPRD_RST;
      st_nxt.tCnt = TPRD_RST;
      st_nxt.timer_pulse_out = 1'b0;
      st_nxt.brTaken = 1'b0;
    end
  end

  // ==========================================================
  // the only clocked process
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st_r <= '0;
      // synchronisers keep sampling so the boot pin is caught in reset
      st_r.syA <= st_nxt.syA;
      st_r.syB <= st_nxt.syB;
      // edge detector follows the pins: a pin held low gives no edge at release
      st_r.irqPrev <= irqLvlN;
      st_r.mcPh <= 1'b0;
      st_r.bus <= B_IDLE;
      st_r.processor_mode_status_reg <= PROCESSOR_MODE_STATUS_REG_RST;
      st_r.processor_mode_status_reg[PROCESSOR_MODE_STATUS_REG_BOOT] <= st_r.syB[SY_BOOT];
      st_r.global_irq_mask_bit <= 1'b1;
      st_r.tPrd <= TPRD_RST;
      st_r.tCnt <= TPRD_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // outputs
  assign extRead = (st_r.bus == B_EXT) && !st_r.req.write;
  assign ctrlOe = st_r.syB[SY_OFF];
  assign busOe = st_r.syB[SY_OFF] & (st_r.bus != B_HOLD);
  assign dataOe = busOe & (st_r.bus == B_EXT) & st_r.req.write;
  assign holdAcknowledgeN = (st_r.bus != B_HOLD);
  assign busCycleStrobeN = (st_r.bus != B_EXT);
  assign busRequestOutN = !((st_r.bus == B_EXT) && st_r.req.global);
  assign externalFlagOut = st_r.xf;
  assign timerPulseOut = st_r.timer_pulse_out;
  assign machineCycleClock = st_r.mcPh;
  assign oscOutputPin = st_r.oscOut;
  assign branchTaken = st_r.brTaken;
  assign coreAck = st_r.ack;
  assign coreRdata = st_r.coreRd;
  assign coreRun = st_r.run;
  assign coreStart = st_r.start;
  assign regRdata = st_r.regRd;
  assign flashSel = (st_r.bus == B_FLASH);

  // general pins; pin zero becomes frame sync in multichannel mode
  always_comb begin
    gpPinsOut = st_r.uctl[UART_OUT+3:UART_OUT];
    gpPinsOe = st_r.uctl[UART_DIR+3:UART_DIR] & {4{st_r.syB[SY_OFF]}};
    if (ssMultichan) begin
      gpPinsOut[0] = ssFrameSync;
      gpPinsOe[0] = st_r.syB[SY_OFF];
    end
  end

  // bus pins from the latched request
  always_comb begin
    busPins = '0;
    busPins.addr = st_r.req.addr;
    busPins.dataOut = st_r.req.wdata;
    busPins.strobeN = busCycleStrobeN;
    busPins.writeN = !((st_r.bus == B_EXT) && st_r.req.write);
    busPins.readNotWrite = busPins.writeN;
    // read pin either strobes reads or shows inverted direction
    busPins.readN = st_r.processor_mode_status_reg[PROCESSOR_MODE_STATUS_REG_RDFN] ? !busPins.writeN : !extRead;
    busPins.progSelN = !((st_r.bus == B_EXT) && st_r.req.space == SP_PROG);
    busPins.dataSelN = !((st_r.bus == B_EXT) && st_r.req.space == SP_DATA);
    busPins.ioSelN = !((st_r.bus == B_EXT) && st_r.req.space == SP_IO);
  end

endmodule

// ### hdl/dspi_pkg.sv
/*
  Package for the pin-level system interface of the signal processor:
  register offsets, field positions, reset values, timing counts, the
  bus sequencer states and the structs that carry core requests and pins.
  Assumes one 40 MHz system clock and a machine cycle of two clocks.
*/
package dspi_pkg;

  // ==========================================================
  // clocking and timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int MC_PERIOD_NS = 50; // machine cycle time
  localparam int MC_CLKS = MC_PERIOD_NS / CLK_PERIOD_NS;
  localparam logic [4:0] RESET_WAIT_MC = 5'h10; // machine cycles after reset release

  // ==========================================================
  // register map (word index on the plain port)
  localparam logic [2:0] REG_PROCESSOR_MODE_STATUS_REG = 3'h0; // processor_mode_status_reg
  localparam logic [2:0] REG_ICR = 3'h1; // irq_control_reg
  localparam logic [2:0] REG_IMR = 3'h2; // interrupt_mask_reg
  localparam logic [2:0] REG_IFR = 3'h3; // interrupt_flag_reg, write one to clear
  localparam logic [2:0] REG_CTRL = 3'h4; // flag output and global mask
  localparam logic [2:0] REG_UART = 3'h5; // uart_control_reg, general pins
  localparam logic [2:0] REG_TPRD = 3'h6; // timer reload value
  localparam logic [2:0] REG_TCNT = 3'h7; // timer count, read only

  // field positions
  localparam int PROCESSOR_MODE_STATUS_REG_BOOT = 0;
  localparam int PROCESSOR_MODE_STATUS_REG_RDFN = 15; // read_pin_function_bit
  localparam int ICR_MODE = 0;
  localparam int CTRL_XF = 0;
  localparam int CTRL_GLOBAL_IRQ_MASK_BIT = 1;
  localparam int UART_DIR = 0; // bits 3:0, one = output
  localparam int UART_OUT = 4; // bits 7:4
  localparam int UART_IN = 8; // bits 11:8, read only
  localparam int IFR_NMI = 3; // bits 2:0 hold irq one to three

  // reset values
  localparam logic [15:0] PROCESSOR_MODE_STATUS_REG_RST = 16'h0000;
  localparam logic [15:0] TPRD_RST = 16'hffff;
  localparam logic [2:0] IMR_RST = 3'h0;
  localparam logic [7:0] UART_RST = 8'h00; // all general pins inputs

  // ==========================================================
  // synchronised pin inputs, bit positions
  localparam int SY_OFF = 0;
  localparam int SY_RST = 1;
  localparam int SY_RDY = 2;
  localparam int SY_BIO = 3;
  localparam int SY_NMI = 4;
  localparam int SY_IRQ1 = 5; // irq one to three at 5..7
  localparam int SY_BOOT = 8;
  localparam int SY_GP = 9; // four general pins at 9..12
  localparam int SY_W = 13;

  // address spaces
  localparam logic [1:0] SP_PROG = 2'h0;
  localparam logic [1:0] SP_DATA = 2'h1;
  localparam logic [1:0] SP_IO = 2'h2;

  typedef enum logic [2:0] {B_IDLE, B_EXT, B_FLASH, B_HOLD} dspi_bus_e_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [1:0] space;
    logic global;
    logic [15:0] addr;
    logic [15:0] wdata;
  } dspi_req_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] dataOut;
    logic strobeN;
    logic writeN;
    logic readN;
    logic readNotWrite;
    logic progSelN;
    logic dataSelN;
    logic ioSelN;
  } dspi_bus_t;

endpackage

// ### bench/dspi_chk.sv
/*
  Checker for the pin-level system interface: watches top ports only.
  Assumes one clock domain, clk_sys, with synchronous reset.
*/
module dspi_chk
  import dspi_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // core side
  input wire dspi_pkg::dspi_req_t coreReq,
  input wire logic coreRun,
  input wire logic coreStart,
  input wire logic branchTest,
  input wire logic branchTaken,
  // pins
  input wire dspi_pkg::dspi_bus_t busPins,
  input wire logic busOe,
  input wire logic dataOe,
  input wire logic floatAllN,
  input wire logic ctrlOe,
  input wire logic busCycleStrobeN,
  input wire logic busRequestOutN,
  input wire logic holdAcknowledgeN,
  input wire logic branchConditionInN,
  input wire logic resetInN,
  input wire logic timerPulseOut,
  input wire logic machineCycleClock
);
  logic [7:0] upCnt_r;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  // ==========================================================
  // cycles since reset release; pin reset restarts the count too
  always_ff @(posedge clk_sys) begin
    if (reset || coreRun || !resetInN) upCnt_r <= 8'h00;
    else if (upCnt_r != 8'hff) upCnt_r <= upCnt_r + 8'h01;
  end
  // ==========================================================
  // pin relations
  AST_WRITE: assert property (!busPins.writeN |-> dataOe && busOe && !busPins.strobeN)
    else $error("write strobe low without driven bus cycle");
  AST_BUS_CYCLE_STROBE: assert property ($fell(busCycleStrobeN) |-> $past(coreReq.valid))
    else $error("bus strobe fell without a core request");
  AST_FLOAT: assert property (!floatAllN [*4] |-> !ctrlOe && !busOe)
    else $error("outputs driven while float-all held low");
  AST_BREQ: assert property ($fell(busRequestOutN) |-> $past(coreReq.global))
    else $error("bus request without global access");
  AST_HOLD: assert property (!holdAcknowledgeN |-> !busOe && !dataOe)
    else $error("hold acknowledged while bus driven");
  AST_BRANCH: assert property (!branchConditionInN [*4] ##0 branchTest |=> branchTaken)
    else $error("branch not taken on low condition pin");
  AST_RSTPIN: assert property (!resetInN [*4] |-> !coreRun)
    else $error("core runs while reset pin low");
  AST_START: assert property ($rose(coreRun) |-> coreStart && upCnt_r >= 8'h1c && upCnt_r <= 8'h28)
    else $error("start not about sixteen machine cycles after reset");
  AST_TIMER_PULSE_OUT: assert property ($rose(timerPulseOut) |=> timerPulseOut ##1 !timerPulseOut)
    else $error("timer pulse not one machine cycle wide");
  AST_MCLK: assert property ($rose(machineCycleClock) |=> !machineCycleClock ##1 machineCycleClock)
    else $error("machine clock not at machine-cycle rate");
endmodule

bind dspi_top dspi_chk u_dspi_chk (.clk_sys, .reset, .coreReq, .coreRun, .coreStart,
  .branchTest, .branchTaken, .busPins, .busOe, .dataOe, .floatAllN, .ctrlOe, .busCycleStrobeN,
  .busRequestOutN, .holdAcknowledgeN, .branchConditionInN, .resetInN, .timerPulseOut,
  .machineCycleClock);

// ### bench/dspi_mem.sv
/*
  External memory model: sixteen words, ready held low for a set wait.
  Assumes the design's bus pins; released data lines show the inverse.
*/
module dspi_mem
  import dspi_pkg::*;
(
  // clock and wait setting
  input wire logic clk_sys,
  input wire logic [2:0] waitStates,
  // bus pins
  input wire dspi_pkg::dspi_bus_t busPins,
  input wire logic busOe,
  output logic [15:0] dataIn,
  output logic readyIn
);
  logic [15:0] mem [16];
  logic [15:0] lastD = 16'h0000;
  logic [15:0] wrA = 16'h0000;
  logic [15:0] wrD = 16'h0000;
  logic [2:0] waitCnt = 3'h0;
  logic wrN = 1'b1;
  // ==========================================================
  // wait counter and write capture on the write strobe's rise
  always @(posedge clk_sys) begin
    if (busPins.strobeN) waitCnt <= 3'h0;
    else if (waitCnt != waitStates) waitCnt <= waitCnt + 3'h1;
    wrN <= busPins.writeN;
    if (!busPins.writeN) begin
      wrA <= busPins.addr;
      wrD <= busPins.dataOut;
    end
    if (busPins.writeN && !wrN) mem[wrA[3:0]] <= wrD;
    if (busOe && !busPins.readN) lastD <= mem[busPins.addr[3:0]];
  end
  // ready pulled high outside cycles; undriven data never repeats
  assign readyIn = busPins.strobeN || waitCnt == waitStates;
  // data only once the wait is over, so a capture before ready shows up
  assign dataIn = (busOe && !busPins.readN && waitCnt == waitStates) ?
    mem[busPins.addr[3:0]] : ~lastD;
endmodule

// ### bench/tb_dsp_system_interface_pins.sv
/*
  Self-checking bench for the pin-level system interface.
  Assumes the memory model on the bus and the bound checker.
*/
module tb_dsp_system_interface_pins;
  timeunit 1ns;
  timeprecision 1ps;
  import dspi_pkg::*;
  // ==========================================================
  // stimulus and observed signals
  logic clk_sys = 0, reset = 1, regWr = 0, regRd = 0, branchTest = 0, irqAck = 0;
  logic floatAllN = 1, branchConditionInN = 1, resetInN = 1, bootMemorySelect = 1;
  logic nmiInN = 1, holdOrIrq1N = 1, extIrqTwoN = 1, extIrqThreeN = 1;
  logic timerEnable = 0, ssMultichan = 0, ssFrameSync = 0;
  logic [2:0] regAddr = 0, waitStates = 0, irqNum;
  logic [15:0] regWdata = 0, flashRdata = 16'h1234, regRdata, coreRdata, dataIn, q;
  logic [3:0] gpPinsIn = 4'h5, gpPinsOut, gpPinsOe;
  logic coreAck, coreRun, coreStart, branchTaken, irqPending, flashSel, busOe, dataOe;
  logic readyIn, ctrlOe, busCycleStrobeN, busRequestOutN, holdAcknowledgeN;
  logic externalFlagOut, timerPulseOut, machineCycleClock;
  logic oscInternalEn = 1'b0, inputClockPin = 1'b0, oscOutputPin;
  dspi_req_t coreReq = '0;
  dspi_bus_t busPins;
  int fail_count = 0, checks_done = 0;
  always #12.5 clk_sys = ~clk_sys;
  dspi_top u_dspi_top (.clk_sys, .reset, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
    .coreReq, .coreAck, .coreRdata, .coreRun, .coreStart, .branchTest, .branchTaken,
    .irqPending, .irqNum, .irqAck, .flashSel, .flashRdata, .timerEnable, .ssMultichan,
    .ssFrameSync, .oscInternalEn, .busPins, .busOe, .dataOe, .dataIn, .readyIn,
    .floatAllN, .ctrlOe, .busCycleStrobeN, .busRequestOutN, .holdAcknowledgeN,
    .externalFlagOut, .branchConditionInN, .gpPinsIn, .gpPinsOut, .gpPinsOe, .resetInN,
    .bootMemorySelect, .nmiInN, .holdOrIrq1N, .extIrqTwoN, .extIrqThreeN, .timerPulseOut,
    .machineCycleClock, .inputClockPin, .oscOutputPin);
  dspi_mem u_dspi_mem (.clk_sys, .waitStates, .busPins, .busOe, .dataIn, .readyIn);
  // ==========================================================
  // shared tasks
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk_sys);
    regWr <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, output logic [15:0] v);
    @(posedge clk_sys);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk_sys);
    regRd <= 1'b0;
    // taken at the edge that ends the data cycle, before it is replaced
    @(posedge clk_sys);
    v = regRdata;
  endtask
  // request held until ack, dropped at the ack edge
  task automatic core(input logic w, input logic g, input logic [1:0] sp,
      input logic [15:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    coreReq <= '{1'b1, w, sp, g, a, d};
    do begin
      @(posedge clk_sys);
      n++;
    end while (coreAck !== 1'b1 && n < 200);
    q = coreRdata;
    coreReq <= '0;
    chk("core ack", 16'(n < 200), 16'h0001);
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ==========================================================
  // scenarios
  task automatic t_regs;
    logic [15:0] e [7] = '{16'h0001, 0, 0, 0, 16'h0002, 16'h0500, 16'hffff};
    for (int i = 0; i < 7; i++) begin
      rd(3'(i), q);
      chk("reset value", q, e[i]);
    end
    chk("gp oe", 16'(gpPinsOe), 16'h0000);
    $display("done regs");
  endtask
  task automatic t_ext;
    waitStates <= 3'h2;
    core(1'b1, 1'b1, SP_DATA, 16'h0005, 16'ha5a5);
    core(1'b0, 1'b0, SP_DATA, 16'h0005, 16'h0000);
    chk("ext read", q, 16'ha5a5);
    $display("done ext");
  endtask
  task automatic t_pins;
    wr(REG_CTRL, 16'h0003);
    cyc(2);
    chk("flag", 16'(externalFlagOut), 16'h0001);
    wr(REG_CTRL, 16'h0002);
    wr(REG_UART, 16'h00af);
    rd(REG_UART, q);
    chk("uart reg", q, 16'h05af);
    chk("gp", {gpPinsOe, gpPinsOut, 7'h0, externalFlagOut}, 16'hfa00);
    ssMultichan <= 1'b1;
    ssFrameSync <= 1'b1;
    cyc(3);
    chk("frame sync", 16'({gpPinsOe[0], gpPinsOut[0]}), 16'h0003);
    ssMultichan <= 1'b0;
    ssFrameSync <= 1'b0;
    oscInternalEn <= 1'b1;
    inputClockPin <= 1'b1;
    cyc(2);
    chk("osc out", 16'(oscOutputPin), 16'h0000);
    inputClockPin <= 1'b0;
    cyc(2);
    chk("osc out", 16'(oscOutputPin), 16'h0001);
    wr(REG_UART, 16'h0000);
    branchConditionInN <= 1'b0;
    cyc(5);
    branchTest <= 1'b1;
    @(posedge clk_sys);
    branchTest <= 1'b0;
    @(posedge clk_sys);
    chk("branch", 16'(branchTaken), 16'h0001);
    branchConditionInN <= 1'b1;
    $display("done pins");
  endtask
  task automatic t_irq;
    nmiInN <= 1'b0;
    cyc(6);
    chk("nmi", {13'h0, irqNum} | 16'(irqPending) << 4, 16'h0014);
    nmiInN <= 1'b1;
    irqAck <= 1'b1;
    @(posedge clk_sys);
    irqAck <= 1'b0;
    extIrqTwoN <= 1'b0;
    cyc(6);
    chk("masked", 16'(irqPending), 16'h0000);
    rd(REG_IFR, q);
    chk("flags", q, 16'h0002);
    wr(REG_IMR, 16'h0002);
    wr(REG_CTRL, 16'h0000);
    cyc(2);
    chk("irq2", {13'h0, irqNum} | 16'(irqPending) << 4, 16'h0012);
    extIrqTwoN <= 1'b1;
    wr(REG_IFR, 16'h0002);
    rd(REG_IFR, q);
    chk("cleared", q, 16'h0000);
    wr(REG_CTRL, 16'h0002);
    $display("done irq");
  endtask
  task automatic t_hold_float;
    holdOrIrq1N <= 1'b0;
    cyc(10);
    chk("hold", {15'h0, holdAcknowledgeN}, 16'h0000);
    holdOrIrq1N <= 1'b1;
    cyc(10);
    floatAllN <= 1'b0;
    cyc(5);
    chk("float", 16'({ctrlOe, busOe}), 16'h0000);
    floatAllN <= 1'b1;
    cyc(5);
    // mode one: the shared pin raises irq one and never holds
    wr(REG_ICR, 16'h0001);
    holdOrIrq1N <= 1'b0;
    cyc(6);
    rd(REG_IFR, q);
    chk("irq1 mode", {q[14:0], holdAcknowledgeN}, 16'h0003);
    holdOrIrq1N <= 1'b1;
    wr(REG_IFR, 16'h0001);
    wr(REG_ICR, 16'h0000);
    $display("done hold float");
  endtask
  task automatic t_timer;
    int n, w;
    wr(REG_TPRD, 16'h0003);
    timerEnable <= 1'b1;
    n = 0;
    w = 0;
    while (timerPulseOut !== 1'b1 && n < 200) begin
      @(posedge clk_sys);
      n++;
    end
    while (timerPulseOut === 1'b1 && w < 20) begin
      @(posedge clk_sys);
      w++;
    end
    n = 0;
    while (timerPulseOut !== 1'b1 && n < 50) begin
      @(posedge clk_sys);
      n++;
    end
    chk("timer_pulse_out width", 16'(w), 16'h0002);
    chk("timer_pulse_out period", 16'(w + n), 16'h0008);
    timerEnable <= 1'b0;
    $display("done timer");
  endtask
  task automatic t_pinreset;
    int n;
    n = 0;
    bootMemorySelect <= 1'b0;
    resetInN <= 1'b0;
    cyc(8);
    chk("halted", 16'(coreRun), 16'h0000);
    resetInN <= 1'b1;
    while (coreStart !== 1'b1 && n < 100) begin
      @(posedge clk_sys);
      n++;
    end
    bootMemorySelect <= 1'b1;
    cyc(4);
    rd(REG_PROCESSOR_MODE_STATUS_REG, q);
    chk("boot bit", q, 16'h0000);
    core(1'b0, 1'b0, SP_PROG, 16'h0000, 16'h0000);
    chk("flash read", q, 16'h1234);
    $display("done pin reset");
  endtask
  // ==========================================================
  // main sequence and watchdog
  initial begin
    cyc(12);
    reset <= 1'b0;
    cyc(60);
    t_regs();
    t_ext();
    t_pins();
    t_irq();
    t_hold_float();
    t_timer();
    t_pinreset();
    finish_test();
  end
  initial begin
    cyc(20000);
    fail_count++;
    finish_test();
  end
endmodule
